// ===== core/vic_consts.vh
// Constants for the vectored interrupt controller: register offsets, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses.
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH
`define VIC_OFF_SMR_BASE 12'h000
`define VIC_OFF_SVR_BASE 12'h080
`define VIC_OFF_IVR 12'h100
`define VIC_OFF_FVR 12'h104
`define VIC_OFF_ISR 12'h108
`define VIC_OFF_IPR 12'h10c
`define VIC_OFF_IMR 12'h110
`define VIC_OFF_CISR 12'h114
`define VIC_OFF_IECR 12'h120
`define VIC_OFF_IDCR 12'h124
`define VIC_OFF_ICCR 12'h128
`define VIC_OFF_ISCR 12'h12c
`define VIC_OFF_EOICR 12'h130
`define VIC_OFF_FFER 12'h140
`define VIC_OFF_FFDR 12'h144
`define VIC_OFF_FFSR 12'h148
`define VIC_BLK_SMR 5'h00
`define VIC_BLK_SVR 5'h01
`define VIC_TYPE_LSB 5
`define VIC_TYPE_MSB 6
`define VIC_PRIO_MSB 2
`define VIC_TYPE_EDGE_BIT 0
`define VIC_TYPE_HIGH_BIT 1
`define VIC_IDLE_LEVEL 4'h0
`define VIC_LEVEL_VALID 3
`define VIC_RESP_OKAY 2'b00
`define VIC_RESP_SLVERR 2'b10
`endif

// ===== core/vic_stack_mem.v
// Nesting stack storage: one word per level, registered read data.
// Assumes the caller never pushes beyond the depth.
`timescale 1ns/1ns
`default_nettype none
module vic_stack_mem #(
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter DW = 9
) (
  // Clock
  input wire clk,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // Read port
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:DEPTH-1];
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // vic_stack_mem
`default_nettype wire

// ===== core/vic_top.v
// Vectored normal/fast interrupt controller with an AXI4-Lite register slave.
// Assumes interrupt source pins are asynchronous and synchronises them.
// Operation
// - Vector read picks highest pending enabled source
// - Vector read releases normal request line
// - Vector read clears edge-triggered current source
// - Vector read pushes level and number
// - Vector read returns selected source handler
// - Higher priority pending reasserts normal request
// - End-of-service pops stack, restoring level
// - After pop, higher than restored reasserts
// - Fast path unprioritised; priority field reads back
// - Source 0 type selects four triggers
// - Enable/disable commands drive mask bit 0
// - Fast vector read returns source 0 handler
// - Fast read clears only edge source 0
// - Redirect set/clear update redirect state
// - Redirected sources skip normal arbitration
// - Active redirected source asserts fast request
// - Redirection leaves source 0 pending alone
// - Fast read never clears redirected sources
// - Normal read never clears redirected sources
// - Source 0 stays a fast source
// - Ties go to lowest source number
// - Eight-entry nesting stack
// - Two-bit trigger type field
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "vic_consts.vh"
module vic_top #(
  parameter NSRC = 32,
  parameter DEPTH = 8
) (
  // Clock and reset
  input wire CLK,
  input wire RSTN,
  // Interrupt sources
  input wire [NSRC-1:0] IRQ_SRC,
  // Requests to the core
  output reg NORMAL_REQ_N,
  output reg FAST_REQ_N,
  // AXI4-Lite write address
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  // AXI4-Lite write response
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // AXI4-Lite read address
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  // Two-flop synchroniser; only the second stage feeds logic.
  reg [NSRC-1:0] sync1_reg;
  reg [NSRC-1:0] sync2_reg;
  reg [NSRC-1:0] prev_reg;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_reg <= {NSRC{1'b0}};
      sync2_reg <= {NSRC{1'b0}};
      prev_reg <= {NSRC{1'b0}};
    end else begin
      sync1_reg <= IRQ_SRC;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Per-source configuration.
  reg [2:0] prio_reg [0:NSRC-1];
  reg [1:0] type_reg [0:NSRC-1];
  reg [31:0] svr_reg [0:NSRC-1];
  reg [NSRC-1:0] enable_reg;
  reg [NSRC-1:0] force_reg;
  reg [NSRC-1:0] edge_pend_reg;

  // Write channel capture: address and data accepted in either order.
  reg aw_full_reg;
  reg w_full_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  assign S_AXI_AWREADY = !aw_full_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_full_reg && !S_AXI_BVALID;
  // Byte strobes are ignored: every register takes whole words only.
  // The commit comes one cycle after both halves are held, so the decode never reads the bus pins.
  wire wr_go = aw_full_reg && w_full_reg && !S_AXI_BVALID;
  wire [31:0] wd = wdata_reg;
  wire wr_blk_smr = wr_go && awaddr_reg[11:7] == `VIC_BLK_SMR;
  wire wr_blk_svr = wr_go && awaddr_reg[11:7] == `VIC_BLK_SVR;
  wire [4:0] wr_idx = awaddr_reg[6:2];
  wire wr_iecr = wr_go && awaddr_reg == `VIC_OFF_IECR;
  wire wr_idcr = wr_go && awaddr_reg == `VIC_OFF_IDCR;
  wire wr_iccr = wr_go && awaddr_reg == `VIC_OFF_ICCR;
  wire wr_iscr = wr_go && awaddr_reg == `VIC_OFF_ISCR;
  wire wr_eoi = wr_go && awaddr_reg == `VIC_OFF_EOICR;
  wire wr_ffer = wr_go && awaddr_reg == `VIC_OFF_FFER;
  wire wr_ffdr = wr_go && awaddr_reg == `VIC_OFF_FFDR;
  wire wr_known = wr_blk_smr || wr_blk_svr || wr_iecr || wr_idcr || wr_iccr || wr_iscr ||
                  wr_eoi || wr_ffer || wr_ffdr;

  // Read channel.
  // Read side effects act at the edge that takes the address, before the data is seen.
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  wire rd_go = S_AXI_ARVALID && !S_AXI_RVALID;
  wire rd_ivr = rd_go && S_AXI_ARADDR == `VIC_OFF_IVR;
  wire rd_fvr = rd_go && S_AXI_ARADDR == `VIC_OFF_FVR;

  // Trigger detection per source: level follows the pin, edge is latched.
  wire [NSRC-1:0] active;
  wire [NSRC-1:0] is_edge;
  wire [NSRC-1:0] pending;
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_src
      wire hi = type_reg[g][`VIC_TYPE_HIGH_BIT];
      wire lvl = hi ? sync2_reg[g] : !sync2_reg[g];
      wire edg = hi ? (sync2_reg[g] && !prev_reg[g]) : (!sync2_reg[g] && prev_reg[g]);
      assign is_edge[g] = type_reg[g][`VIC_TYPE_EDGE_BIT];
      assign active[g] = is_edge[g] ? edg : lvl;
      assign pending[g] = is_edge[g] ? edge_pend_reg[g] : lvl;
    end
  endgenerate

  // Nesting state.
  reg [4:0] cur_src_reg;
  reg [3:0] cur_level_reg;
  reg [3:0] sp_reg;
  wire [8:0] top_entry;

  // Arbitration over sources 1..N-1, not redirected, enabled and pending.
  // Source 0 never competes here: it only ever drives the fast line.
  reg [4:0] win_src;
  reg [2:0] win_prio;
  reg win_valid;
  integer i;
  always @* begin
    win_src = 5'h00;
    win_prio = 3'h0;
    win_valid = 1'b0;
    for (i = NSRC - 1; i >= 1; i = i - 1) begin
      if (pending[i] && enable_reg[i] && !force_reg[i] &&
          (!win_valid || prio_reg[i] >= win_prio)) begin
        win_valid = 1'b1;
        win_prio = prio_reg[i];
        win_src = i[4:0];
      end
    end
  end
  // Idle level sits below priority 0 so any source can interrupt.
  wire [3:0] win_level = {1'b1, win_prio};
  wire irq_wanted = win_valid && (win_level > cur_level_reg);

  // Fast request: enabled source 0 plus every enabled, redirected, pending source.
  wire [NSRC-1:0] fast_terms = (pending & enable_reg & force_reg) |
                               {{(NSRC-1){1'b0}}, pending[0] & enable_reg[0]};

  // Vector read: arbitration result is taken at the read.
  // A ninth nested read still moves the level but its entry is dropped, so its pop restores the seventh.
  // A pop in the same cycle as a vector read that takes a source is lost; software keeps the two apart.
  wire ivr_take = rd_ivr && irq_wanted;
  wire stack_push = ivr_take && sp_reg < DEPTH[3:0];
  wire stack_pop = wr_eoi && sp_reg != 4'h0;

  // The stack read port is registered, so a pop must come at least two cycles after the push it undoes.
  vic_stack_mem #(
    .DEPTH(DEPTH),
    .AW(3),
    .DW(9)
  ) u_stack (
    .clk(CLK),
    .wr_en(stack_push),
    .wr_addr(sp_reg[2:0]),
    .wr_data({cur_level_reg, cur_src_reg}),
    .rd_addr(sp_reg[2:0] - 3'h1),
    .rd_data(top_entry)
  );

  // Configuration and pending state.
  // Set and clear commands only touch edge sources; a level source's pending state is its pin.
  reg [NSRC-1:0] edge_set;
  reg [NSRC-1:0] edge_clr;
  always @* begin
    edge_set = active & is_edge;
    if (wr_iscr) begin
      edge_set = edge_set | (wd[NSRC-1:0] & is_edge);
    end
    edge_clr = {NSRC{1'b0}};
    if (wr_iccr) begin
      edge_clr = wd[NSRC-1:0];
    end
    if (ivr_take && !force_reg[win_src]) begin
      edge_clr[win_src] = 1'b1;
    end
    // While any source is redirected the fast read clears nothing, so no forced edge is lost.
    if (rd_fvr && is_edge[0] && !(|force_reg)) begin
      edge_clr[0] = 1'b1;
    end
  end

  integer k;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (k = 0; k < NSRC; k = k + 1) begin
        prio_reg[k] <= 3'h0;
        type_reg[k] <= 2'h0;
        svr_reg[k] <= 32'h0000_0000;
      end
      enable_reg <= {NSRC{1'b0}};
      force_reg <= {NSRC{1'b0}};
      edge_pend_reg <= {NSRC{1'b0}};
      cur_src_reg <= 5'h00;
      cur_level_reg <= `VIC_IDLE_LEVEL;
      sp_reg <= 4'h0;
    end else begin
      // A new edge wins over a clear in the same cycle.
      edge_pend_reg <= (edge_pend_reg & ~edge_clr) | edge_set;
      if (wr_blk_smr) begin
        prio_reg[wr_idx] <= wd[`VIC_PRIO_MSB:0];
        type_reg[wr_idx] <= wd[`VIC_TYPE_MSB:`VIC_TYPE_LSB];
      end
      if (wr_blk_svr) begin
        svr_reg[wr_idx] <= wd;
      end
      if (wr_iecr) begin
        enable_reg <= enable_reg | wd[NSRC-1:0];
      end
      if (wr_idcr) begin
        enable_reg <= enable_reg & ~wd[NSRC-1:0];
      end
      if (wr_ffer) begin
        force_reg <= force_reg | (wd[NSRC-1:0] & ~{{(NSRC-1){1'b0}}, 1'b1});
      end
      if (wr_ffdr) begin
        force_reg <= force_reg & ~wd[NSRC-1:0];
      end
      if (ivr_take) begin
        cur_src_reg <= win_src;
        cur_level_reg <= win_level;
        if (stack_push) begin
          sp_reg <= sp_reg + 4'h1;
        end
      end else if (stack_pop) begin
        sp_reg <= sp_reg - 4'h1;
        cur_level_reg <= top_entry[8:5];
        cur_src_reg <= top_entry[4:0];
      end
    end
  end

  // Request outputs: registered, active low. Normal request drops on a vector read.
  // Registering both lines keeps arbitration glitches away from the core.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      NORMAL_REQ_N <= 1'b1;
      FAST_REQ_N <= 1'b1;
    end else begin
      NORMAL_REQ_N <= !(irq_wanted && !rd_ivr && !stack_pop);
      FAST_REQ_N <= !(|fast_terms) || (rd_fvr && is_edge[0] && !(|force_reg));
    end
  end

  // Register read mux.
  // Unmapped and write-only offsets answer with an error and have no side effect.
  reg [31:0] rdata_next;
  reg rd_hit;
  wire [4:0] rd_idx = S_AXI_ARADDR[6:2];
  always @* begin
    rdata_next = 32'h0000_0000;
    rd_hit = 1'b1;
    if (S_AXI_ARADDR[11:7] == `VIC_BLK_SMR) begin
      rdata_next = {25'h0, type_reg[rd_idx], 2'h0, prio_reg[rd_idx]};
    end else if (S_AXI_ARADDR[11:7] == `VIC_BLK_SVR) begin
      rdata_next = svr_reg[rd_idx];
    end else begin
      case (S_AXI_ARADDR)
        `VIC_OFF_IVR: rdata_next = irq_wanted ? svr_reg[win_src] : 32'h0000_0000;
        `VIC_OFF_FVR: rdata_next = svr_reg[0];
        `VIC_OFF_ISR: rdata_next = {27'h0, cur_src_reg};
        `VIC_OFF_IPR: rdata_next = pending;
        `VIC_OFF_IMR: rdata_next = enable_reg;
        `VIC_OFF_CISR: rdata_next = {30'h0, !NORMAL_REQ_N, !FAST_REQ_N};
        `VIC_OFF_FFSR: rdata_next = force_reg;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // AXI handshake state.
  // A response stands until its ready is seen; no new address is taken meanwhile.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `VIC_RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP <= `VIC_RESP_OKAY;
      S_AXI_RDATA <= 32'h0000_0000;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_known ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (rd_go) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rdata_next;
        S_AXI_RRESP <= rd_hit ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule // vic_top
`default_nettype wire

// ===== tb/vic_src_model.sv
// Interrupt source side: peripheral lines into the controller.
// Assumes the bench sets the wanted levels just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module vic_src_model (
  // Clock
  input wire logic clk,
  // Wanted source levels
  input wire logic [31:0] want,
  // Source lines
  output var logic [31:0] irq_src
);
  // Lines move only after an edge, like a clocked peripheral.
  always @(posedge clk) begin
    irq_src <= want;
  end
endmodule // vic_src_model
`default_nettype wire

// ===== tb/vic_top_sva.sv
// Checker for the request lines and the register bus.
// Assumes it is bound to vic_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module vic_top_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Requests
  input wire logic NORMAL_REQ_N,
  input wire logic FAST_REQ_N,
  // Write channels
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  // Read channels
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_ar;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  property p_req_reset;
    $rose(RSTN) |-> NORMAL_REQ_N && FAST_REQ_N;
  endproperty
  property p_ivr_release;
    s_ar ##0 S_AXI_ARADDR == 12'h100 |=> NORMAL_REQ_N;
  endproperty
  property p_rd_answer;
    s_ar |=> S_AXI_RVALID;
  endproperty
  property p_ar_block;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  property p_r_done;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
  endproperty
  property p_b_answer;
    s_wr |-> ##2 S_AXI_BVALID;
  endproperty
  property p_b_block;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  property p_wo_read;
    s_ar ##0 S_AXI_ARADDR == 12'h130 |=> S_AXI_RRESP == 2'b10;
  endproperty
  a_req_reset: assert property (p_req_reset)
    else $error("request line low after reset");
  a_ivr_release: assert property (p_ivr_release)
    else $error("normal request kept after vector read");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while answer pending");
  a_r_done: assert property (p_r_done)
    else $error("read answer not retired");
  a_b_answer: assert property (p_b_answer)
    else $error("write answer late");
  a_b_block: assert property (p_b_block)
    else $error("write taken while answer pending");
  a_wo_read: assert property (p_wo_read)
    else $error("command register read not refused");
endmodule // vic_top_sva
bind vic_top vic_top_sva u_vic_top_sva (.CLK(CLK), .RSTN(RSTN), .NORMAL_REQ_N(NORMAL_REQ_N),
  .FAST_REQ_N(FAST_REQ_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
`default_nettype wire

// ===== tb/vic_top_tb_top.sv
// Self-checking bench for the interrupt controller.
// Assumes the source model and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module vic_top_tb_top;
  logic clk = 0;
  logic rstn = 0;
  logic [31:0] want = 0;
  logic [11:0] awaddr = 0;
  logic [11:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic awv = 0;
  logic wv = 0;
  logic bready = 0;
  logic arv = 0;
  logic rready = 0;
  wire [31:0] irq_src;
  wire [31:0] rdata;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire awready, wready, bvalid, arready, rvalid, nreq, freq;
  int fail_count = 0;
  int total_checks = 0;
  int w;
  logic [31:0] rs = 32'h1a50;
  logic [31:0] d;
  logic [31:0] v0;
  logic [1:0] r;
  logic [2:0] pr [1:4];
  logic [31:0] vec [1:4];
  logic [4:0] live;
  always #4 clk = ~clk;
  vic_src_model u_vic_src_model (.clk(clk), .want(want), .irq_src(irq_src));
  vic_top u_vic_top (.CLK(clk), .RSTN(rstn), .IRQ_SRC(irq_src), .NORMAL_REQ_N(nreq), .FAST_REQ_N(freq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Strict comparison keeps the lower source number on a tie.
  function automatic int win();
    int b;
    b = 0;
    for (int i = 1; i < 5; i++)
      if (live[i] && (b == 0 || pr[i] > pr[b])) b = i;
    return b;
  endfunction
  // Ready stays high between transfers so back-to-back calls never drive it twice in one step.
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awv <= 0;
      if (wready) wv <= 0;
    end while (!bvalid);
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arv <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rd(12'h110); `CHK(d, 32'h0)
    rd(12'h130); `CHK(r, 2'b10)
    $display("test reset done");
    v0 = xs();
    wr(12'h080, v0);
    wr(12'h120, 32'h1);
    rd(12'h110); `CHK(d, 32'h1)
    for (int t = 0; t < 4; t++) begin
      want[0] <= ~t[1];
      wr(12'h000, 32'(t * 32 + 5));
      rd(12'h000); `CHK(d, 32'(t * 32 + 5))
      repeat (6) @(posedge clk);
      wr(12'h128, 32'h1);
      repeat (4) @(posedge clk);
      `CHK(freq, 1'b1)
      want[0] <= t[1];
      repeat (8) @(posedge clk);
      `CHK(freq, 1'b0)
      rd(12'h104); `CHK(d, v0)
      repeat (4) @(posedge clk);
      `CHK(freq, t[0])
    end
    wr(12'h124, 32'h1);
    rd(12'h110); `CHK(d, 32'h0)
    $display("test fast source done");
    for (int i = 1; i < 5; i++) begin
      v0 = xs();
      pr[i] = v0[2:0];
      vec[i] = xs();
      wr(12'(i * 4), 32'(8'h60 + pr[i]));
      wr(12'(32'h80 + i * 4), vec[i]);
    end
    wr(12'h120, 32'h1e);
    wr(12'h130, 32'h0);
    repeat (4) @(posedge clk);
    `CHK(nreq, 1'b1)
    want[4:1] <= 4'hf;
    live = 5'h1e;
    repeat (8) @(posedge clk);
    `CHK(nreq, 1'b0)
    repeat (4) begin
      w = win();
      rd(12'h100); `CHK(d, vec[w])
      `CHK(nreq, 1'b1)
      live[w] = 0;
      rd(12'h108); `CHK(d, 32'(w))
      wr(12'h130, 32'h0);
      repeat (4) @(posedge clk);
      `CHK(nreq, live == 0)
    end
    $display("test normal arbitration done");
    wr(12'h004, 32'h61);
    wr(12'h008, 32'h66);
    wr(12'h00c, 32'h63);
    wr(12'h12c, 32'h2);
    repeat (4) @(posedge clk);
    rd(12'h100); `CHK(d, vec[1])
    wr(12'h12c, 32'h4);
    repeat (4) @(posedge clk);
    `CHK(nreq, 1'b0)
    rd(12'h100); `CHK(d, vec[2])
    wr(12'h12c, 32'h8);
    repeat (4) @(posedge clk);
    `CHK(nreq, 1'b1)
    wr(12'h130, 32'h0);
    repeat (4) @(posedge clk);
    `CHK(nreq, 1'b0)
    rd(12'h108); `CHK(d, 32'h1)
    rd(12'h100); `CHK(d, vec[3])
    wr(12'h130, 32'h0);
    wr(12'h130, 32'h0);
    rd(12'h108); `CHK(d, 32'h0)
    repeat (4) @(posedge clk);
    `CHK(nreq, 1'b1)
    $display("test nesting done");
    wr(12'h018, 32'h40);
    wr(12'h120, 32'h40);
    wr(12'h140, 32'h40);
    rd(12'h148); `CHK(d, 32'h40)
    want[6] <= 1;
    repeat (8) @(posedge clk);
    `CHK(freq, 1'b0)
    `CHK(nreq, 1'b1)
    rd(12'h10c); `CHK(d[0], 1'b0)
    want[6] <= 0;
    wr(12'h144, 32'h40);
    rd(12'h148); `CHK(d, 32'h0)
    repeat (8) @(posedge clk);
    `CHK(freq, 1'b1)
    wr(12'h014, 32'h60);
    wr(12'h120, 32'h20);
    wr(12'h140, 32'h20);
    wr(12'h12c, 32'h20);
    rd(12'h104);
    rd(12'h100);
    repeat (4) @(posedge clk);
    `CHK(freq, 1'b0)
    `CHK(nreq, 1'b1)
    wr(12'h128, 32'h20);
    repeat (4) @(posedge clk);
    `CHK(freq, 1'b1)
    $display("test fast redirect done");
    print_verdict();
  end
endmodule // vic_top_tb_top
`default_nettype wire
